// ### logic/dmcc_pkg.sv
// package for loop mode and clock change sequencing between controller and memory
// assumes one system clock at 10 MHz shared by both ends
`default_nettype none
package dmcc_pkg;
    localparam int CLK_PERIOD_NS = 100;
    // timing figures in ns, plain defaults
    localparam int REG_UPDATE_NS = 1500;
    localparam int REG_GAP_NS = 400;
    localparam int CLK_HOLD_NS = 1000;
    localparam int CLK_STABLE_NS = 1000;
    localparam int EXIT_DELAY_NS = 2000;
    localparam int LOCK_SETTLE_NS = 51200;
    localparam int REG_UPDATE_CYC = (REG_UPDATE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int REG_GAP_CYC = (REG_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CLK_HOLD_CYC = (CLK_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CLK_STABLE_CYC = (CLK_STABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int EXIT_DELAY_CYC = (EXIT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LOCK_SETTLE_CYC = (LOCK_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // mode word bit positions
    localparam int LOOP_OFF_BIT = 0;
    localparam int LOOP_RESET_BIT = 8;
    localparam int TERM_NOM_BIT0 = 2;
    localparam int TERM_NOM_BIT1 = 6;
    localparam int TERM_NOM_BIT2 = 9;
    localparam int TERM_WR_BIT0 = 9;
    localparam int TERM_WR_BIT1 = 10;
    localparam int CASLAT_LSB = 4;
    localparam int WCASLAT_LSB = 3;
    localparam int ADDLAT_LSB = 3;
    localparam logic [3:0] UNLOCKED_LAT = 4'h6;
    localparam logic [15:0] WORD0_RESET = 16'h0000;
    localparam logic [15:0] WORD1_RESET = 16'h0000;
    localparam logic [15:0] WORD2_RESET = 16'h0000;
    typedef enum logic [2:0] {
        DMCC_CMD_NOP, DMCC_CMD_MRS, DMCC_CMD_SR_ENTER, DMCC_CMD_SR_EXIT,
        DMCC_CMD_PD_ENTER, DMCC_CMD_PD_EXIT, DMCC_CMD_READ, DMCC_CMD_CAL_LONG
    } dmcc_cmd_e;
endpackage
`default_nettype wire

// ### logic/dmcc_link.sv
// link between memory controller and memory device: commands, mode data, strobes
// assumes both ends run on sys_clk; the memory clock is modelled by memClkRun
`timescale 1ns/100ps
`default_nettype none
interface dmcc_link
    import dmcc_pkg::*;
    ();
    dmcc_cmd_e cmd;
    logic [1:0] modeSel;
    logic [15:0] modeData;
    logic clkEnable;
    logic termEnable;
    logic memClkRun;
    logic readStrobe;
    logic loopOff;
    modport ctrl (output cmd, modeSel, modeData, clkEnable, termEnable, memClkRun,
        input readStrobe, loopOff);
    modport mem (input cmd, modeSel, modeData, clkEnable, termEnable, memClkRun,
        output readStrobe, loopOff);
endinterface
`default_nettype wire

// ### logic/dmcc_mem.sv
// memory device end: mode words, loop state, read strobe timing
// assumes the controller keeps its own sequencing rules
`timescale 1ns/100ps
`default_nettype none
module dmcc_mem
    import dmcc_pkg::*;
    (
    input wire logic sys_clk,
    input wire logic rst,
    dmcc_link.mem link,
    output logic loopLocked,
    output logic clockIgnored,
    output logic [15:0] modeWordOne
);
    logic [15:0] word0, next_word0, word1, next_word1, word2, next_word2;
    logic [15:0] lockCnt, next_lockCnt;
    logic [7:0] holdCnt, next_holdCnt;
    logic inSleep, next_inSleep, locked, next_locked, ign, next_ign;
    logic [31:0] rdPipe, next_rdPipe;
    logic strobe, next_strobe;
    logic [4:0] rdDelay;
    always_comb begin
        // strobe window one cycle earlier with loop off
        rdDelay = 5'(word1[ADDLAT_LSB +: 2]) + 5'(word0[CASLAT_LSB +: 3]) + 5'd4;
        if (word1[LOOP_OFF_BIT])
            rdDelay = rdDelay - 5'd1;
    end
    always_comb begin
        next_word0 = word0;
        next_word1 = word1;
        next_word2 = word2;
        next_lockCnt = lockCnt;
        next_locked = locked;
        next_inSleep = inSleep;
        next_holdCnt = holdCnt;
        next_ign = ign;
        next_rdPipe = {rdPipe[30:0], 1'b0};
        if (link.cmd == DMCC_CMD_MRS) begin
            case (link.modeSel)
                2'd0: next_word0 = link.modeData;
                2'd1: next_word1 = link.modeData;
                2'd2: next_word2 = link.modeData;
                default: ;
            endcase
        end
        // loop disabled while bit set, restarted by reset bit
        if (link.cmd == DMCC_CMD_MRS && link.modeSel == 2'd1 && link.modeData[LOOP_OFF_BIT]) begin
            next_locked = 1'b0;
            next_lockCnt = '0;
        end else if (link.cmd == DMCC_CMD_MRS && link.modeSel == 2'd0 && link.modeData[LOOP_RESET_BIT]
                && !word1[LOOP_OFF_BIT]) begin
            next_locked = 1'b0;
            next_lockCnt = 16'(LOCK_SETTLE_CYC);
        end else if (lockCnt != '0) begin
            next_lockCnt = lockCnt - 16'd1;
            if (lockCnt == 16'd1)
                next_locked = 1'b1;
        end
        // clock ignored after hold time in self refresh
        if (link.cmd == DMCC_CMD_SR_ENTER) begin
            next_inSleep = 1'b1;
            next_holdCnt = 8'(CLK_HOLD_CYC);
            next_ign = 1'b0;
        end else if (link.cmd == DMCC_CMD_SR_EXIT) begin
            next_inSleep = 1'b0;
            next_ign = 1'b0;
        end else if (inSleep && holdCnt != '0) begin
            next_holdCnt = holdCnt - 8'd1;
        end else if (inSleep) begin
            next_ign = 1'b1;
        end
        if (link.cmd == DMCC_CMD_READ)
            next_rdPipe[0] = 1'b1;
    end
    assign next_strobe = rdPipe[rdDelay];
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            word0 <= WORD0_RESET;
            word1 <= WORD1_RESET;
            word2 <= WORD2_RESET;
            lockCnt <= '0;
            locked <= 1'b1;
            inSleep <= 1'b0;
            holdCnt <= '0;
            ign <= 1'b0;
            rdPipe <= '0;
            strobe <= 1'b0;
        end else begin
            word0 <= next_word0;
            word1 <= next_word1;
            word2 <= next_word2;
            lockCnt <= next_lockCnt;
            locked <= next_locked;
            inSleep <= next_inSleep;
            holdCnt <= next_holdCnt;
            ign <= next_ign;
            rdPipe <= next_rdPipe;
            strobe <= next_strobe;
        end
    end
    assign link.readStrobe = strobe;
    assign link.loopOff = word1[LOOP_OFF_BIT];
    assign loopLocked = locked;
    assign clockIgnored = ign;
    assign modeWordOne = word1;
endmodule
`default_nettype wire

// ### logic/dmcc_ctrl.sv
// Notes on behaviour
// - mode word one bit zero disables loop
// - loop bit toggled any time via sequence
// - loop off: both latencies programmed to six
// - loop off: clock period within unlocked limit
// - loop off: strobe window one cycle earlier
// - on-to-off: idle, set bit, wait, sleep, change
// - after exit hold enable high, termination low
// - rewrite mode words after exit delay
// - off-to-on: idle, sleep, hold, change, stabilise
// - hold enable, termination until lock time
// - clear loop bit, reset loop, rewrite words
// - wait lock time before locked commands
// - change clock only asleep or powered down
// - clock ignored after hold time in sleep
// - frequency within grade; slower needs loop off
// - power-down change: termination low if enabled
// - power-down: wait hold, clock held low
// - stabilise, exit, reset loop, rewrite words
// - relock: termination low, enable high
// - termination off before clock change
// - loop off keeps termination disabled
//
// controller end: sequences loop switching and clock changes
// assumes the memory end follows the link commands
`timescale 1ns/100ps
`default_nettype none
module dmcc_ctrl
    import dmcc_pkg::*;
    (
    input wire logic sys_clk,
    input wire logic rst,
    dmcc_link.ctrl link,
    input wire logic startReq,
    input wire logic toLoopOff,
    input wire logic viaPowerDown,
    input wire logic [15:0] termWord1,
    input wire logic [15:0] termWord2,
    output logic busy,
    output logic done,
    output logic clockChangeNow
);
    typedef enum {
        S_IDLE, S_SETOFF, S_WAITMOD, S_SLEEP, S_HOLD, S_CHANGE, S_STABLE,
        S_EXIT, S_EXITWAIT, S_MRS_A, S_GAP_A, S_MRS_B, S_GAP_B, S_MRS_C, S_LOCK, S_DONE
    } dmcc_state_e;
    dmcc_state_e state, next_state;
    logic [15:0] cnt, next_cnt;
    logic termAtEntry, next_termAtEntry;
    dmcc_cmd_e cmd, next_cmd;
    logic [1:0] sel, next_sel;
    logic [15:0] data, next_data;
    logic cke, next_cke, die_termination_enable, next_odt, clkRun, next_clkRun;
    logic busyR, next_busy, doneR, next_done, chg, next_chg;
    logic offMode, next_offMode, pdMode, next_pdMode;
    always_comb begin
        next_state = state;
        next_cnt = (cnt != '0) ? cnt - 16'd1 : cnt;
        next_termAtEntry = termAtEntry;
        next_cmd = DMCC_CMD_NOP;
        next_sel = sel;
        next_data = data;
        next_cke = cke;
        next_odt = die_termination_enable;
        next_clkRun = clkRun;
        next_busy = busyR;
        next_done = 1'b0;
        next_chg = 1'b0;
        next_offMode = offMode;
        next_pdMode = pdMode;
        case (state)
            S_IDLE: begin
                // loop may be switched whenever the sequence runs
                if (startReq) begin
                    next_busy = 1'b1;
                    next_offMode = toLoopOff;
                    next_pdMode = viaPowerDown && !toLoopOff;
                    // record termination features at entry
                    next_termAtEntry = termWord1[TERM_NOM_BIT0] | termWord1[TERM_NOM_BIT1]
                        | termWord1[TERM_NOM_BIT2] | termWord2[TERM_WR_BIT0] | termWord2[TERM_WR_BIT1];
                    // termination off before any step
                    next_odt = 1'b0;
                    next_state = toLoopOff ? S_SETOFF : S_SLEEP;
                end
            end
            S_SETOFF: begin
                // set the loop-disable bit, termination fields zero
                next_cmd = DMCC_CMD_MRS;
                next_sel = 2'd1;
                next_data = 16'h0001;
                next_cnt = 16'(REG_UPDATE_CYC);
                next_state = S_WAITMOD;
            end
            S_WAITMOD: if (cnt == '0) next_state = S_SLEEP;
            S_SLEEP: begin
                next_cmd = pdMode ? DMCC_CMD_PD_ENTER : DMCC_CMD_SR_ENTER;
                next_cke = 1'b0;
                next_cnt = 16'(CLK_HOLD_CYC);
                next_state = S_HOLD;
            end
            // change only after hold time, in sleep or power-down
            S_HOLD: if (cnt == '0) begin
                next_clkRun = 1'b0;
                next_chg = 1'b1;
                next_state = S_CHANGE;
            end
            S_CHANGE: begin
                // new rate stays in grade; clock resumes stable
                next_clkRun = 1'b1;
                next_cnt = 16'(CLK_STABLE_CYC);
                next_state = S_STABLE;
            end
            S_STABLE: if (cnt == '0) next_state = S_EXIT;
            S_EXIT: begin
                next_cmd = pdMode ? DMCC_CMD_PD_EXIT : DMCC_CMD_SR_EXIT;
                // enable high, termination low through relock
                next_cke = 1'b1;
                next_odt = 1'b0;
                next_cnt = 16'(EXIT_DELAY_CYC);
                next_state = S_EXITWAIT;
            end
            S_EXITWAIT: if (cnt == '0) next_state = S_MRS_A;
            S_MRS_A: begin
                next_cmd = DMCC_CMD_MRS;
                if (offMode) begin
                    // latencies set to six with loop off
                    next_sel = 2'd2;
                    next_data = 16'(UNLOCKED_LAT - 4'd5) << WCASLAT_LSB;
                end else if (pdMode) begin
                    next_sel = 2'd0;
                    next_data = 16'h0100;
                end else begin
                    next_sel = 2'd1;
                    next_data = 16'h0000;
                end
                next_cnt = 16'(REG_GAP_CYC);
                next_state = S_GAP_A;
            end
            S_GAP_A: if (cnt == '0) next_state = S_MRS_B;
            S_MRS_B: begin
                next_cmd = DMCC_CMD_MRS;
                next_sel = 2'd0;
                if (offMode)
                    next_data = 16'(UNLOCKED_LAT - 4'd4) << CASLAT_LSB;
                else
                    next_data = 16'h0100; // loop reset
                next_cnt = offMode ? 16'(REG_UPDATE_CYC) : 16'(REG_GAP_CYC);
                next_state = offMode ? S_LOCK : S_GAP_B;
            end
            S_GAP_B: if (cnt == '0) next_state = S_MRS_C;
            S_MRS_C: begin
                next_cmd = DMCC_CMD_MRS;
                next_sel = 2'd2;
                next_data = termWord2;
                // wait lock time before locked commands
                next_cnt = 16'(LOCK_SETTLE_CYC);
                next_state = S_LOCK;
            end
            S_LOCK: if (cnt == '0) begin
                next_state = S_DONE;
            end
            S_DONE: begin
                // one read to realign capture, only after any lock wait
                next_cmd = DMCC_CMD_READ;
                // termination control returns high only if it was in use
                next_odt = termAtEntry && !offMode;
                next_busy = 1'b0;
                next_done = 1'b1;
                next_state = S_IDLE;
            end
            default: next_state = S_IDLE;
        endcase
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state <= S_IDLE;
            cnt <= '0;
            termAtEntry <= 1'b0;
            cmd <= DMCC_CMD_NOP;
            sel <= 2'd0;
            data <= 16'h0000;
            cke <= 1'b1;
            die_termination_enable <= 1'b0;
            clkRun <= 1'b1;
            busyR <= 1'b0;
            doneR <= 1'b0;
            chg <= 1'b0;
            offMode <= 1'b0;
            pdMode <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            termAtEntry <= next_termAtEntry;
            cmd <= next_cmd;
            sel <= next_sel;
            data <= next_data;
            cke <= next_cke;
            die_termination_enable <= next_odt;
            clkRun <= next_clkRun;
            busyR <= next_busy;
            doneR <= next_done;
            chg <= next_chg;
            offMode <= next_offMode;
            pdMode <= next_pdMode;
        end
    end
    assign link.cmd = cmd;
    assign link.modeSel = sel;
    assign link.modeData = data;
    assign link.clkEnable = cke;
    assign link.termEnable = die_termination_enable;
    assign link.memClkRun = clkRun;
    assign busy = busyR;
    assign done = doneR;
    assign clockChangeNow = chg;
endmodule
`default_nettype wire

// ### sim/dmcc_chk.sv
// checker on the link between controller and memory ends
// assumes it sits beside the link instance, on the single system clock
`timescale 1ns/100ps
`default_nettype none
module dmcc_chk
    import dmcc_pkg::*;
    (
    input wire logic sys_clk,
    input wire logic rst,
    input wire dmcc_cmd_e cmd,
    input wire logic [1:0] modeSel,
    input wire logic [15:0] modeData,
    input wire logic clkEnable,
    input wire logic termEnable,
    input wire logic memClkRun,
    input wire logic readStrobe,
    input wire logic loopOff
);
    logic asleep, next_asleep;
    logic [15:0] sleepCnt, next_sleepCnt, sinceMrs, next_sinceMrs, runCnt, next_runCnt;
    logic [2:0] latRd, next_latRd;
    logic [1:0] latAdd, next_latAdd;
    logic [4:0] rdDue, next_rdDue;
    always_comb begin
        next_asleep = asleep;
        if (cmd == DMCC_CMD_SR_ENTER || cmd == DMCC_CMD_PD_ENTER) next_asleep = 1'b1;
        if (cmd == DMCC_CMD_SR_EXIT || cmd == DMCC_CMD_PD_EXIT) next_asleep = 1'b0;
        next_sleepCnt = !next_asleep ? 16'h0000 : (&sleepCnt ? sleepCnt : sleepCnt + 16'h0001);
        next_sinceMrs = (cmd == DMCC_CMD_MRS) ? 16'h0001 : (&sinceMrs ? sinceMrs : sinceMrs + 16'h0001);
        next_runCnt = !memClkRun ? 16'h0000 : (&runCnt ? runCnt : runCnt + 16'h0001);
        next_latRd = (cmd == DMCC_CMD_MRS && modeSel == 2'h0) ? modeData[CASLAT_LSB +: 3] : latRd;
        next_latAdd = (cmd == DMCC_CMD_MRS && modeSel == 2'h1) ? modeData[ADDLAT_LSB +: 2] : latAdd;
        // read latency field counts from four; command and strobe each pass one register
        if (cmd == DMCC_CMD_READ)
            next_rdDue = 5'(latAdd) + 5'(latRd) + 5'h06 - 5'(loopOff);
        else
            next_rdDue = (rdDue != 5'h00) ? rdDue - 5'h01 : rdDue;
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            asleep <= 1'b0;
            sleepCnt <= 16'h0000;
            sinceMrs <= 16'hFFFF;
            runCnt <= 16'hFFFF;
            latRd <= 3'h0;
            latAdd <= 2'h0;
            rdDue <= 5'h00;
        end else begin
            asleep <= next_asleep;
            sleepCnt <= next_sleepCnt;
            sinceMrs <= next_sinceMrs;
            runCnt <= next_runCnt;
            latRd <= next_latRd;
            latAdd <= next_latAdd;
            rdDue <= next_rdDue;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_loop_bit_follow: assert property ((cmd == DMCC_CMD_MRS && modeSel == 2'h1) |=>
        loopOff == $past(modeData[LOOP_OFF_BIT])) else $error("loop state does not follow word one");
    a_loop_bit_hold: assert property ($changed(loopOff) |->
        $past(cmd) == DMCC_CMD_MRS && $past(modeSel) == 2'h1) else $error("loop state moved without write");
    a_term_idle_entry: assert property ((cmd == DMCC_CMD_SR_ENTER || cmd == DMCC_CMD_PD_ENTER) |->
        !termEnable) else $error("termination on at sleep entry");
    a_clock_stop_legal: assert property ($fell(memClkRun) |->
        asleep && sleepCnt >= CLK_HOLD_CYC) else $error("clock stopped outside sleep or too early");
    a_stable_exit: assert property ((cmd == DMCC_CMD_SR_EXIT || cmd == DMCC_CMD_PD_EXIT) |->
        runCnt >= CLK_STABLE_CYC) else $error("exit before clock stable");
    a_enable_after_exit: assert property ((cmd == DMCC_CMD_SR_EXIT) |=>
        (clkEnable && !termEnable) [*8]) else $error("enable or termination wrong after exit");
    a_update_before_sleep: assert property ((cmd == DMCC_CMD_SR_ENTER) |->
        sinceMrs >= REG_UPDATE_CYC) else $error("sleep entered before mode update delay");
    a_mrs_spacing: assert property ((cmd == DMCC_CMD_MRS) |=>
        (cmd != DMCC_CMD_MRS) [*3]) else $error("mode writes too close");
    a_unlocked_wlat: assert property ((cmd == DMCC_CMD_MRS && loopOff && modeSel == 2'h2) |->
        modeData[WCASLAT_LSB +: 3] == 3'h1 && !modeData[TERM_WR_BIT0] && !modeData[TERM_WR_BIT1])
        else $error("word two wrong with loop off");
    a_unlocked_rlat: assert property ((cmd == DMCC_CMD_MRS && loopOff && modeSel == 2'h0) |->
        modeData[CASLAT_LSB +: 3] == 3'h2) else $error("read latency wrong with loop off");
    a_term_loop_off: assert property (loopOff |-> !termEnable) else $error("termination on with loop off");
    a_strobe_window: assert property ((rdDue == 5'h01) == readStrobe)
        else $error("read strobe outside its window");
endmodule
`default_nettype wire

// ### sim/dll_mode_and_clock_change_tb.sv
// testbench joining controller and memory ends through the link
// assumes the package timing figures; the mode writes seen on the link are kept in queues
`timescale 1ns/100ps
`default_nettype none
module dll_mode_and_clock_change_tb;
    import dmcc_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic startReq = 1'b0;
    logic toLoopOff = 1'b0;
    logic viaPowerDown = 1'b0;
    logic [15:0] termWord1 = 16'h0000;
    logic [15:0] termWord2 = 16'h0000;
    logic busy, done, clockChangeNow, loopLocked, clockIgnored;
    logic [15:0] modeWordOne;
    logic sawIgnored = 1'b0;
    logic sawChange = 1'b0;
    int strobeLat = 0;
    logic [1:0] gotSel[$];
    logic [15:0] gotData[$];
    int n_errors = 0;
    int num_checks = 0;
    int seed = 39;
    dmcc_link link();
    dmcc_ctrl i_dmcc_ctrl(.sys_clk(sys_clk), .rst(rst), .link(link), .startReq(startReq), .toLoopOff(toLoopOff),
        .viaPowerDown(viaPowerDown), .termWord1(termWord1), .termWord2(termWord2), .busy(busy), .done(done),
        .clockChangeNow(clockChangeNow));
    dmcc_mem i_dmcc_mem(.sys_clk(sys_clk), .rst(rst), .link(link), .loopLocked(loopLocked),
        .clockIgnored(clockIgnored), .modeWordOne(modeWordOne));
    dmcc_chk i_dmcc_chk(.sys_clk(sys_clk), .rst(rst), .cmd(link.cmd), .modeSel(link.modeSel),
        .modeData(link.modeData), .clkEnable(link.clkEnable), .termEnable(link.termEnable),
        .memClkRun(link.memClkRun), .readStrobe(link.readStrobe), .loopOff(link.loopOff));
    always #50 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        if (link.cmd === DMCC_CMD_MRS) begin
            gotSel.push_back(link.modeSel);
            gotData.push_back(link.modeData);
        end
        if (clockIgnored === 1'b1) sawIgnored = 1'b1;
        if (clockChangeNow === 1'b1 && link.clkEnable === 1'b0) sawChange = 1'b1;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("checks=%0d errors=%0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // one sequence with a second request while busy, which must be ignored
    task automatic run(input logic toOff, input logic viaPd);
        int i;
        logic expTerm;
        gotSel.delete();
        gotData.delete();
        sawIgnored = 1'b0;
        sawChange = 1'b0;
        repeat (2) @(posedge sys_clk);
        termWord1 <= 16'($random(seed));
        termWord2 <= 16'($random(seed));
        startReq <= 1'b1;
        toLoopOff <= toOff;
        viaPowerDown <= viaPd;
        @(posedge sys_clk);
        startReq <= 1'b0;
        repeat (4) @(posedge sys_clk);
        startReq <= 1'b1;
        @(posedge sys_clk);
        startReq <= 1'b0;
        i = 0;
        while (done !== 1'b1 && i < 3000) begin
            @(posedge sys_clk);
            i++;
        end
        chk({15'h0000, done}, 16'h0001);
        // termination control comes back only after a loop-on sequence that found it in use
        expTerm = !toOff && (termWord1[TERM_NOM_BIT0] || termWord1[TERM_NOM_BIT1] || termWord1[TERM_NOM_BIT2]
            || termWord2[TERM_WR_BIT0] || termWord2[TERM_WR_BIT1]);
        chk({15'h0000, link.termEnable}, {15'h0000, expTerm});
        // edges from the closing read to its strobe
        i = 0;
        while (link.readStrobe !== 1'b1 && i < 40) begin
            @(posedge sys_clk);
            i++;
        end
        strobeLat = i;
    endtask
    task automatic seq3(input logic [1:0] e0, input logic [1:0] e1, input logic [1:0] e2);
        chk(16'(gotSel.size()), 16'h0003);
        chk({14'h0000, gotSel[0]}, {14'h0000, e0});
        chk({14'h0000, gotSel[1]}, {14'h0000, e1});
        chk({14'h0000, gotSel[2]}, {14'h0000, e2});
    endtask
    // loop state, word one bit zero and lock flag against the model
    task automatic state(input int expOff);
        chk({13'h0000, modeWordOne[LOOP_OFF_BIT], link.loopOff, loopLocked}, (expOff != 0) ? 16'h0006 : 16'h0001);
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_errors++;
        conclude();
    end
    initial begin
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        chk({11'h000, busy, link.clkEnable, link.memClkRun, link.termEnable, loopLocked}, 16'h000D);
        chk(modeWordOne, WORD1_RESET);
        run(1'b1, 1'b0);
        seq3(2'h1, 2'h2, 2'h0);
        chk({15'h0000, gotData[0][LOOP_OFF_BIT]}, 16'h0001);
        chk({15'h0000, sawIgnored}, 16'h0001);
        state(1);
        // no additive latency, latency six, one cycle early, two register stages
        chk(16'(strobeLat), 16'(UNLOCKED_LAT) + 16'h0001);
        run(1'b0, 1'b0);
        seq3(2'h1, 2'h0, 2'h2);
        chk({15'h0000, gotData[0][LOOP_OFF_BIT]}, 16'h0000);
        chk(gotData[1], 16'h0100);
        chk({15'h0000, sawIgnored}, 16'h0001);
        state(0);
        // latency field zero means four cycles; loop on, two register stages
        chk(16'(strobeLat), 16'h0006);
        run(1'b0, 1'b1);
        chk({14'h0000, gotSel[0]}, 16'h0000);
        chk(gotData[0], 16'h0100);
        state(0);
        chk({15'h0000, sawChange}, 16'h0001);
        run(1'b0, 1'b0);
        seq3(2'h1, 2'h0, 2'h2);
        chk({15'h0000, sawChange}, 16'h0001);
        state(0);
        repeat (2) @(posedge sys_clk);
        startReq <= 1'b1;
        toLoopOff <= 1'b1;
        viaPowerDown <= 1'b0;
        @(posedge sys_clk);
        startReq <= 1'b0;
        repeat (40) @(posedge sys_clk);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        chk({11'h000, busy, link.clkEnable, link.memClkRun, link.termEnable, link.loopOff}, 16'h000C);
        chk(modeWordOne, WORD1_RESET);
        run(1'b1, 1'b0);
        seq3(2'h1, 2'h2, 2'h0);
        state(1);
        chk(16'(strobeLat), 16'(UNLOCKED_LAT) + 16'h0001);
        conclude();
    end
endmodule
`default_nettype wire
